// file: rtcts_params.svh
// Constants for the RTC trim and supply-flag link ends
`ifndef RTCTS_PARAMS_SVH
`define RTCTS_PARAMS_SVH
`define RTCTS_REF_MHZ    25
`define RTCTS_XTAL_HZ    32768
`define RTCTS_REG_SEC    4'h0
`define RTCTS_REG_TRIM   4'h7
`define RTCTS_REG_CTRL1  4'he
`define RTCTS_REG_CTRL2  4'hf
`define RTCTS_FLG_PU     4
`define RTCTS_FLG_HALT   5
`define RTCTS_FLG_LOW    6
`define RTCTS_TRIM_SEL   7
`define RTCTS_CTRL1_RST  8'h00
`define RTCTS_TRIM_RST   8'h00
`define RTCTS_CT_1HZ     4'h3
`define RTCTS_PER_COARSE 6'd19
`define RTCTS_PER_FINE   6'd59
`define RTCTS_WIN_US     7800
`define RTCTS_HALT_US    122
`define RTCTS_START_MS   125
`define RTCTS_QTR_NS     2500
`define RTCTS_HOST_CMD   2'h0
`define RTCTS_HOST_DATA  2'h1
`define RTCTS_HOST_STAT  2'h2
`define RTCTS_HOST_RX    2'h3
`endif

// file: rtcts_pkg.sv
// Types for the two link ends: device slave states and host sequencer states
package rtcts_pkg;
  typedef enum logic [4:0] {
    RTCTS_SL_IDLE  = 5'h01,
    RTCTS_SL_RX    = 5'h02,
    RTCTS_SL_ACK   = 5'h04,
    RTCTS_SL_TX    = 5'h08,
    RTCTS_SL_TXACK = 5'h10
  } rtcts_sl_e;
  typedef enum logic [3:0] {
    RTCTS_HS_IDLE  = 4'h1,
    RTCTS_HS_START = 4'h2,
    RTCTS_HS_BITS  = 4'h4,
    RTCTS_HS_STOP  = 4'h8
  } rtcts_hs_e;
endpackage

// file: rtcts_link_if.sv
// Two-wire link between host and clock device
`timescale 1ns/100ps
interface rtcts_link_if;
  logic scl;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic sda;
  // Open drain: a low from either end wins
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));
  modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
  modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface

// file: rtcts_device.sv
// Clock device end: trim, second count, health flags, link slave
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "rtcts_params.svh"

module rtcts_device
  import rtcts_pkg::*;
#(
  parameter int SEC_TICKS   = `RTCTS_XTAL_HZ,
  parameter int START_TICKS = `RTCTS_START_MS * `RTCTS_XTAL_HZ / 1000
) (
  input  wire logic  ref_clk,
  input  wire logic  nrst,
  rtcts_link_if.dev  link,
  input  wire logic  xtal_in,
  input  wire logic  supply_low_in,
  output logic       crystal_clock_out,
  output logic       interrupt_out_n
);
  localparam int HALT_CYC = (`RTCTS_HALT_US * `RTCTS_REF_MHZ);
  localparam int WIN_TICKS = `RTCTS_WIN_US * `RTCTS_XTAL_HZ / 1000000;
  localparam logic [16:0] SEC_LEN = 17'(SEC_TICKS);
  localparam logic [12:0] START_LEN = 13'(START_TICKS);
  localparam logic [11:0] HALT_LEN = 12'(HALT_CYC);
  localparam logic [16:0] WIN_LEN = 17'(WIN_TICKS);

  // Pin synchronisers: scl, sda, xtal, supply comparator
  logic [3:0]  s1_ff;
  logic [3:0]  s2_ff;
  logic [2:0]  d_ff;
  logic [12:0] start_cnt_ff;
  logic [11:0] halt_cnt_ff;
  logic [16:0] sec_cnt_ff;
  logic [5:0]  per_cnt_ff;
  logic [7:0]  sec_num_ff;
  logic [7:0]  ctrl1_ff;
  logic [7:0]  trim_ff;
  logic        pu_ff;
  logic        halt_ff;
  logic        low_ff;
  logic        xout_ff;
  logic        int_n_ff;
  rtcts_sl_e   st_ff;
  logic [7:0]  sh_ff;
  logic [3:0]  bit_ff;
  logic        first_ff;
  logic        rd_ff;
  logic [3:0]  ra_ff;
  logic        oe_ff;
  logic        wr_ff;
  logic [7:0]  wd_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 4'h3;
      s2_ff <= 4'h3;
      d_ff  <= 3'h3;
    end else begin
      s1_ff <= {supply_low_in, xtal_in, link.sda, link.scl};
      s2_ff <= s1_ff;
      d_ff  <= s2_ff[2:0];
    end
  end

  wire scl      = s2_ff[0];
  wire sda      = s2_ff[1];
  wire xtal     = s2_ff[2];
  wire sup_low  = s2_ff[3];
  wire scl_rise = scl & ~d_ff[0];
  wire scl_fall = ~scl & d_ff[0];
  wire i2c_sta  = scl & d_ff[0] & ~sda & d_ff[1];
  wire i2c_sto  = scl & d_ff[0] & sda & ~d_ff[1];
  wire tick     = xtal & ~d_ff[2];
  wire por_busy = (start_cnt_ff != START_LEN);
  wire halt_evt = (halt_cnt_ff == HALT_LEN - 12'd1) & ~tick;

  // Trim decode
  wire [6:0]  code    = trim_ff[6:0];
  wire        neutral = (code == 7'h00) | (code == 7'h01) |
                        (code == 7'h40) | (code == 7'h41);
  wire        fast    = ~code[6] & ~neutral;
  wire        slow    = code[6] & ~neutral;
  wire [7:0]  slow_st = 8'h80 - {1'b0, code};
  wire [6:0]  steps   = fast ? code - 7'h01 : slow_st[6:0];
  // Two crystal cycles per step: 20 s x 3.051 ppm or 60 s x 1.017 ppm
  wire [16:0] adj     = {9'h000, steps, 1'b0};
  wire        corr    = (per_cnt_ff == 6'd0);
  wire [16:0] cur_len = (corr & fast) ? SEC_LEN - adj :
                        (corr & slow) ? SEC_LEN + adj :
                        SEC_LEN;
  wire [5:0]  per_end = trim_ff[`RTCTS_TRIM_SEL] ?
                        `RTCTS_PER_FINE : `RTCTS_PER_COARSE;
  // A trim write in a corrected second may shorten it below the count
  // already reached; ending on >= keeps the count from running away
  wire        sec_end = tick & (sec_cnt_ff >= cur_len - 17'd1);
  wire        half    = sec_cnt_ff < {1'b0, cur_len[16:1]};
  wire        win     = sec_cnt_ff < WIN_LEN;
  wire        low_set = win & sup_low & ~low_ff & ~por_busy;

  // Register writes from the link
  wire wr_c1  = wr_ff & (ra_ff == `RTCTS_REG_CTRL1);
  wire wr_c2  = wr_ff & (ra_ff == `RTCTS_REG_CTRL2);
  wire wr_tr  = wr_ff & (ra_ff == `RTCTS_REG_TRIM);
  wire clr_pu = wr_c2 & ~wd_ff[`RTCTS_FLG_PU];
  wire clr_ht = wr_c2 & ~wd_ff[`RTCTS_FLG_HALT];
  wire clr_lo = wr_c2 & ~wd_ff[`RTCTS_FLG_LOW];
  wire [7:0] ctrl2 = {1'b0, low_ff, halt_ff, pu_ff, 4'h0};
  wire [7:0] rd_val = (ra_ff == `RTCTS_REG_SEC)   ? sec_num_ff :
                      (ra_ff == `RTCTS_REG_TRIM)  ? trim_ff :
                      (ra_ff == `RTCTS_REG_CTRL1) ? ctrl1_ff :
                      (ra_ff == `RTCTS_REG_CTRL2) ? ctrl2 : 8'h00;

  // Oscillator start and halt watch
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      start_cnt_ff <= 13'h0000;
      halt_cnt_ff  <= 12'h000;
    end else begin
      if (tick & por_busy)
        start_cnt_ff <= start_cnt_ff + 13'h0001;
      if (tick)
        halt_cnt_ff <= 12'h000;
      else if (halt_cnt_ff != HALT_LEN)
        halt_cnt_ff <= halt_cnt_ff + 12'h001;
    end
  end

  // Second count on crystal ticks
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sec_cnt_ff <= 17'h00000;
      per_cnt_ff <= 6'h00;
      sec_num_ff <= 8'h00;
    end else if (tick) begin
      sec_cnt_ff <= sec_end ? 17'h00000 : sec_cnt_ff + 17'h00001;
      if (sec_end) begin
        per_cnt_ff <= (per_cnt_ff >= per_end) ? 6'h00
                                              : per_cnt_ff + 6'h01;
        sec_num_ff <= sec_num_ff + 8'h01;
      end
    end
  end

  // Control, trim and flags; hardware set beats a host clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_ff <= `RTCTS_CTRL1_RST;
      trim_ff  <= `RTCTS_TRIM_RST;
      pu_ff    <= 1'b1;
      halt_ff  <= 1'b1;
      low_ff   <= 1'b1;
    end else begin
      if (wr_c1)
        ctrl1_ff <= wd_ff;
      if (wr_tr)
        trim_ff <= wd_ff;
      pu_ff   <= pu_ff & ~clr_pu;
      halt_ff <= halt_evt | (halt_ff & ~clr_ht);
      low_ff  <= low_set | (low_ff & ~clr_lo);
    end
  end

  // Pin outputs; crystal out follows the raw crystal, not the trim
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      xout_ff  <= 1'b0;
      int_n_ff <= 1'b1;
    end else begin
      xout_ff  <= xtal;
      int_n_ff <= ~((ctrl1_ff[3:0] == `RTCTS_CT_1HZ) & half);
    end
  end

  assign crystal_clock_out = xout_ff;
  assign interrupt_out_n   = int_n_ff;

  // Link slave: byte 0 {reg[3:0], read, 000}, byte 1 data
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff    <= RTCTS_SL_IDLE;
      sh_ff    <= 8'h00;
      bit_ff   <= 4'h0;
      first_ff <= 1'b0;
      rd_ff    <= 1'b0;
      ra_ff    <= 4'h0;
      oe_ff    <= 1'b0;
      wr_ff    <= 1'b0;
      wd_ff    <= 8'h00;
    end else begin
      wr_ff <= 1'b0;
      if (i2c_sto) begin
        st_ff <= RTCTS_SL_IDLE;
        oe_ff <= 1'b0;
      end else if (i2c_sta) begin
        st_ff    <= RTCTS_SL_RX;
        bit_ff   <= 4'h0;
        first_ff <= 1'b1;
        oe_ff    <= 1'b0;
      end else begin
        case (st_ff)
          RTCTS_SL_IDLE: begin
            oe_ff <= 1'b0;
          end
          RTCTS_SL_RX: begin
            if (scl_rise && bit_ff != 4'h8) begin
              sh_ff  <= {sh_ff[6:0], sda};
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall && bit_ff == 4'h8) begin
              if (first_ff && por_busy) begin
                st_ff <= RTCTS_SL_IDLE;
              end else begin
                if (first_ff) begin
                  ra_ff <= sh_ff[7:4];
                  rd_ff <= sh_ff[3];
                end else begin
                  wr_ff <= 1'b1;
                  wd_ff <= sh_ff;
                end
                oe_ff <= 1'b1;
                st_ff <= RTCTS_SL_ACK;
              end
            end
          end
          RTCTS_SL_ACK: begin
            if (scl_fall) begin
              if (rd_ff && first_ff) begin
                sh_ff  <= {rd_val[6:0], 1'b0};
                oe_ff  <= ~rd_val[7];
                bit_ff <= 4'h1;
                st_ff  <= RTCTS_SL_TX;
              end else begin
                oe_ff  <= 1'b0;
                bit_ff <= 4'h0;
                st_ff  <= RTCTS_SL_RX;
              end
              first_ff <= 1'b0;
            end
          end
          RTCTS_SL_TX: begin
            if (scl_fall) begin
              if (bit_ff == 4'h8) begin
                oe_ff <= 1'b0;
                st_ff <= RTCTS_SL_TXACK;
              end else begin
                oe_ff  <= ~sh_ff[7];
                sh_ff  <= {sh_ff[6:0], 1'b0};
                bit_ff <= bit_ff + 4'h1;
              end
            end
          end
          RTCTS_SL_TXACK: begin
            if (scl_fall)
              st_ff <= RTCTS_SL_IDLE;
          end
          default: begin
            st_ff <= RTCTS_SL_IDLE;
            oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign link.sda_d_o  = 1'b0;
  assign link.sda_d_oe = oe_ff;
endmodule

// file: rtcts_host.sv
// Host end: register port to two-wire link master
`timescale 1ns/100ps
`include "rtcts_params.svh"
module rtcts_host
  import rtcts_pkg::*;
#(
  parameter int QTR_CYC = (`RTCTS_QTR_NS * `RTCTS_REF_MHZ + 999) / 1000
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  rtcts_link_if.host       link,
  input  wire logic [1:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata
);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

  rtcts_hs_e   st_ff;
  logic [7:0]  q_ff;
  logic [1:0]  ph_ff;
  logic [4:0]  bi_ff;
  logic [17:0] tx_ff;
  logic [17:0] rx_ff;
  logic [7:0]  data_ff;
  logic [7:0]  res_ff;
  logic        nack_ff;
  logic        rdm_ff;
  logic        scl_ff;
  logic        oe_ff;
  logic [7:0]  rdata_ff;
  logic [1:0]  sda_s_ff;

  wire busy  = (st_ff != RTCTS_HS_IDLE);
  wire qtick = (q_ff == QTR_LAST);
  wire go    = wr & (addr == `RTCTS_HOST_CMD) & ~busy;
  // Device drives sda from another clock; synchronise before sampling
  wire sda   = sda_s_ff[1];
  wire [7:0] stat = {6'h00, nack_ff, busy};
  wire [7:0] rmux = (addr == `RTCTS_HOST_DATA) ? data_ff :
                    (addr == `RTCTS_HOST_STAT) ? stat :
                    (addr == `RTCTS_HOST_RX)   ? res_ff : 8'h00;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sda_s_ff <= 2'h3;
      rdata_ff <= 8'h00;
      data_ff  <= 8'h00;
    end else begin
      sda_s_ff <= {sda_s_ff[0], link.sda};
      rdata_ff <= rd ? rmux : 8'h00;
      if (wr && addr == `RTCTS_HOST_DATA)
        data_ff <= wdata;
    end
  end

  // Quarter-bit sequencer; a write needs the data byte whole
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff   <= RTCTS_HS_IDLE;
      q_ff    <= 8'h00;
      ph_ff   <= 2'h0;
      bi_ff   <= 5'h00;
      tx_ff   <= 18'h3ffff;
      rx_ff   <= 18'h00000;
      res_ff  <= 8'h00;
      nack_ff <= 1'b0;
      rdm_ff  <= 1'b0;
      scl_ff  <= 1'b1;
      oe_ff   <= 1'b0;
    end else begin
      q_ff <= (qtick || !busy) ? 8'h00 : q_ff + 8'h01;
      if (busy && qtick)
        ph_ff <= ph_ff + 2'h1;
      case (st_ff)
        RTCTS_HS_IDLE: begin
          if (go) begin
            rdm_ff <= wdata[3];
            tx_ff  <= {wdata, 1'b1, wdata[3] ? 8'hff : data_ff, 1'b1};
            ph_ff  <= 2'h0;
            bi_ff  <= 5'h00;
            st_ff  <= RTCTS_HS_START;
          end
        end
        RTCTS_HS_START: begin
          if (qtick) begin
            if (ph_ff == 2'h1)
              oe_ff <= 1'b1;
            if (ph_ff == 2'h2)
              scl_ff <= 1'b0;
            if (ph_ff == 2'h3)
              st_ff <= RTCTS_HS_BITS;
          end
        end
        RTCTS_HS_BITS: begin
          if (qtick) begin
            case (ph_ff)
              2'h0: oe_ff <= ~tx_ff[17];
              2'h1: scl_ff <= 1'b1;
              2'h2: rx_ff <= {rx_ff[16:0], sda};
              default: begin
                scl_ff <= 1'b0;
                tx_ff  <= {tx_ff[16:0], 1'b1};
                bi_ff  <= bi_ff + 5'h01;
                if (bi_ff == 5'd17)
                  st_ff <= RTCTS_HS_STOP;
              end
            endcase
          end
        end
        RTCTS_HS_STOP: begin
          if (qtick) begin
            if (ph_ff == 2'h0)
              oe_ff <= 1'b1;
            if (ph_ff == 2'h1)
              scl_ff <= 1'b1;
            if (ph_ff == 2'h2)
              oe_ff <= 1'b0;
            if (ph_ff == 2'h3) begin
              nack_ff <= rx_ff[9] | (~rdm_ff & rx_ff[0]);
              res_ff  <= rx_ff[8:1];
              st_ff   <= RTCTS_HS_IDLE;
            end
          end
        end
        default: st_ff <= RTCTS_HS_IDLE;
      endcase
    end
  end

  assign link.scl      = scl_ff;
  assign link.sda_h_o  = 1'b0;
  assign link.sda_h_oe = oe_ff;
  assign rdata         = rdata_ff;
endmodule

// file: rtcts_link_sva.sv
// Checks on the two-wire link and the device pins
`timescale 1ns/100ps
module rtcts_link_sva (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_h_o,
  input wire logic sda_h_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic sda,
  input wire logic xtal_in,
  input wire logic crystal_clock_out,
  input wire logic interrupt_out_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Open drain: a driven high would fight the other end
  a_open_drain: assert property (!sda_h_o && !sda_d_o)
    else $error("data line driven high");
  // Device data may only move while the clock line is low
  a_dev_data_stable: assert property ($changed(sda_d_oe) |-> !scl)
    else $error("device data moved with clock high");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("link clock high too short");
  a_clk_follow: assert property (
    $rose(xtal_in) |-> ##[1:6] $rose(crystal_clock_out))
    else $error("crystal clock output missed an edge");
  a_clk_still: assert property (
    $stable(xtal_in) [*6] |=> $stable(crystal_clock_out))
    else $error("crystal clock output moved without input");
  a_reset_quiet: assert property (
    $rose(nrst) |-> interrupt_out_n && !sda_d_oe && scl && !sda_h_oe)
    else $error("pins not idle after reset");
  a_no_early_ack: assert property ($rose(nrst) |-> !sda_d_oe [*8])
    else $error("device answered before oscillator start");
  a_int_low_hold: assert property (
    $fell(interrupt_out_n) |=> !interrupt_out_n [*8])
    else $error("square wave low phase too short");
endmodule

// file: rtc_trim_and_supply_flags_test.sv
// Testbench joining host and device ends over the link
`timescale 1ns/100ps
`include "rtcts_params.svh"
module rtc_trim_and_supply_flags_test;
  logic       ref_clk;
  logic       nrst;
  logic       xtal_in;
  logic       xtal_run;
  logic       supply_low_in;
  logic       wr;
  logic       rd;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       crystal_clock_out;
  logic       interrupt_out_n;
  int         miscompares;
  int         n_tests;
  int         cyc;
  rtcts_link_if lnk();
  rtcts_host #(.QTR_CYC(8)) i_rtcts_host (
    .ref_clk(ref_clk), .nrst(nrst), .link(lnk), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  rtcts_device #(.SEC_TICKS(32), .START_TICKS(4)) i_rtcts_device (
    .ref_clk(ref_clk), .nrst(nrst), .link(lnk), .xtal_in(xtal_in),
    .supply_low_in(supply_low_in), .crystal_clock_out(crystal_clock_out),
    .interrupt_out_n(interrupt_out_n));
  rtcts_link_sva i_rtcts_link_sva (
    .ref_clk(ref_clk), .nrst(nrst), .scl(lnk.scl), .sda_h_o(lnk.sda_h_o),
    .sda_h_oe(lnk.sda_h_oe), .sda_d_o(lnk.sda_d_o),
    .sda_d_oe(lnk.sda_d_oe), .sda(lnk.sda), .xtal_in(xtal_in),
    .crystal_clock_out(crystal_clock_out),
    .interrupt_out_n(interrupt_out_n));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Crystal stands still until started, phase unrelated to ref_clk
  initial begin
    xtal_in = 1'b0;
    #37;
    forever begin
      #160;
      if (xtal_run) xtal_in = ~xtal_in;
    end
  end
  task check(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 98000) begin
      miscompares++;
      complete_run;
    end
  end
  task bus_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task bus_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // One frame: poll busy, then fetch the byte on a read
  task xfer(input logic [3:0] r, input logic rw, input logic [7:0] d,
            output logic [7:0] q, output logic nk);
    logic [7:0] s;
    int i;
    bus_wr(2'h1, d);
    bus_wr(2'h0, {r, rw, 3'h0});
    s = 8'h01;
    for (i = 0; i < 1000 && s[0] !== 1'b0; i++) bus_rd(2'h2, s);
    check("frame done", s[0], 1'b0);
    nk = s[1];
    q = 8'h00;
    if (rw) bus_rd(2'h3, q);
  endtask
  task wreg(input logic [3:0] r, input logic [7:0] d);
    logic [7:0] q;
    logic nk;
    xfer(r, 1'b0, d, q, nk);
    check("write ack", nk, 1'b0);
  endtask
  task rchk(input string nm, input logic [3:0] r, input logic [7:0] e);
    logic [7:0] q;
    logic nk;
    xfer(r, 1'b1, 8'h00, q, nk);
    check(nm, q, e);
  endtask
  task edge_wait(input logic lvl, output realtime t);
    int i;
    for (i = 0; i < 4000 && interrupt_out_n !== lvl; i++) @(posedge ref_clk);
    t = $realtime;
  endtask
  task t_early;
    logic [7:0] q;
    logic nk;
    xfer(`RTCTS_REG_TRIM, 1'b1, 8'h00, q, nk);
    check("early nack", nk, 1'b1);
  endtask
  task t_reset_vals;
    rchk("ctrl1", `RTCTS_REG_CTRL1, `RTCTS_CTRL1_RST);
    rchk("trim", `RTCTS_REG_TRIM, `RTCTS_TRIM_RST);
    rchk("flags", `RTCTS_REG_CTRL2, 8'h70);
  endtask
  task t_flags;
    wreg(`RTCTS_REG_CTRL2, 8'h70);
    rchk("flags keep", `RTCTS_REG_CTRL2, 8'h70);
    wreg(`RTCTS_REG_CTRL2, 8'h00);
    rchk("flags clear", `RTCTS_REG_CTRL2, 8'h00);
    wreg(`RTCTS_REG_CTRL2, 8'h70);
    rchk("flags no set", `RTCTS_REG_CTRL2, 8'h00);
  endtask
  task t_supply;
    @(posedge ref_clk);
    supply_low_in <= 1'b1;
    repeat (100) @(posedge ref_clk);
    supply_low_in <= 1'b0;
    rchk("low only", `RTCTS_REG_CTRL2, 8'h40);
    wreg(`RTCTS_REG_CTRL2, 8'h00);
    rchk("low clear", `RTCTS_REG_CTRL2, 8'h00);
  endtask
  // Halt longer than the detector limit, then let it run again
  task t_halt;
    xtal_run = 1'b0;
    repeat (3300) @(posedge ref_clk);
    xtal_run = 1'b1;
    repeat (50) @(posedge ref_clk);
    rchk("halt", `RTCTS_REG_CTRL2, 8'h20);
    rchk("halt keep", `RTCTS_REG_CTRL2, 8'h20);
    wreg(`RTCTS_REG_CTRL2, 8'h00);
    rchk("halt clear", `RTCTS_REG_CTRL2, 8'h00);
  endtask
  // Summed square-wave periods show one corrected second per span
  task t_trim;
    logic [7:0] codes [7];
    realtime t0;
    realtime t1;
    real dl;
    int k;
    int n;
    int c;
    int dt;
    codes = '{8'h00, 8'h01, 8'h40, 8'h41,
              8'h05, 8'h7e, 8'h83};
    wreg(`RTCTS_REG_CTRL1, 8'h03);
    edge_wait(1'b1, t0);
    edge_wait(1'b0, t0);
    edge_wait(1'b1, t1);
    dl = t1 - t0 - 16 * 320.0;
    check("half second", dl < 100 && dl > -100, 1'b1);
    for (k = 0; k < 7; k++) begin
      wreg(`RTCTS_REG_TRIM, codes[k]);
      rchk("trim back", `RTCTS_REG_TRIM, codes[k]);
      n = codes[k][7] ? 60 : 20;
      c = codes[k][6:0];
      dt = (c >= 2 && c <= 63) ? -2 * (c - 1) :
           (c >= 66) ? 2 * (128 - c) : 0;
      edge_wait(1'b1, t0);
      edge_wait(1'b0, t0);
      repeat (n) begin
        edge_wait(1'b1, t1);
        edge_wait(1'b0, t1);
      end
      dl = t1 - t0 - (n * 32 + dt) * 320.0;
      check("span", dl < 100 && dl > -100, 1'b1);
    end
  endtask
  initial begin
    miscompares = 0;
    n_tests = 0;
    cyc = 0;
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    supply_low_in = 1'b0;
    xtal_run = 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_early;
    xtal_run = 1'b1;
    repeat (100) @(posedge ref_clk);
    t_reset_vals;
    t_flags;
    t_supply;
    t_halt;
    t_trim;
    complete_run;
  end
endmodule
